// file: design/sep_host.sv
// Bus controller that drives the serial EEPROM over its two-wire pins
`timescale 1ns/1ps
`default_nettype none
module sep_host
   import sep_pkg::*;
#(
   parameter int QTR_CYC = sep_pkg::QTR_CYC_DEF,
   parameter int PROG_CYC = sep_pkg::PROG_CYC_DEF,
   parameter int ADDR_W = sep_pkg::ADDR_W_LARGE,
   parameter bit FIXED_ADDR = 1'b0,
   parameter logic [3:0] DEV_TYPE = sep_pkg::DEV_TYPE_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Command
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_op,
   input wire logic [2:0] cmd_cs,
   input wire logic [15:0] cmd_addr,
   input wire logic [sep_pkg::LEN_W-1:0] cmd_len,
   output logic busy,
   output logic done,
   output logic err,
   // Write data
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   // Read data
   output logic rd_valid,
   output logic [7:0] rd_data,
   // Protect
   input wire logic write_protect,
   output logic wp,
   // Bus pins
   output logic scl_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import sep_pkg::*;
   localparam logic [DIV_W-1:0] QTR_LAST = DIV_W'(QTR_CYC - 1);
   localparam logic [PTMR_W-1:0] PROG_LIM = PTMR_W'(PROG_CYC);
   localparam logic [15:0] ADDR_MASK = 16'((32'h1 << ADDR_W) - 32'h1);
   localparam logic [3:0] REC_LAST = 4'(REC_PULSES - 1);

   sep_reg_t r, n;
   logic sda_s;
   logic [7:0] dev_byte;
   logic nak;

   sep_sync #(.W(1)) u_sda_sync (
      .clk(clk),
      .srst(srst),
      .d(sda_i),
      .q(sda_s)
   );

   // ==========================================================
   // Next state
   always_comb begin
      n = r;
      n.tick = 1'b0;
      n.rd_valid = 1'b0;
      n.done = 1'b0;
      n.wp = write_protect;
      n.sda_o = 1'b0;
      dev_byte = {DEV_TYPE, r.cs, r.step == S_DEVR};
      nak = r.ack;
      if (r.div == QTR_LAST) begin
         n.div = '0;
         n.tick = 1'b1;
      end else begin
         n.div = r.div + 1'b1;
      end
      // Bounds the wait for the self-timed program cycle
      if (r.step == S_POLL && r.ptmr != PROG_LIM) begin
         n.ptmr = r.ptmr + 1'b1;
      end
      unique case (r.st)
         ST_IDLE: begin
            n.scl = 1'b1;
            n.sda_oe = 1'b0;
            n.cmd_ready = 1'b1;
            if (cmd_valid && r.cmd_ready) begin
               n.cmd_ready = 1'b0;
               n.busy = 1'b1;
               n.err = 1'b0;
               n.op = cmd_op;
               n.cs = FIXED_ADDR ? 3'h0 : cmd_cs;
               n.addr = cmd_addr & ADDR_MASK;
               n.cnt = (cmd_len == '0) ? LEN_ONE : cmd_len;
               if (cmd_op == OP_WRITE && cmd_len > LEN_PAGE) begin
                  n.cnt = LEN_PAGE;
               end
               n.qtr = 2'h0;
               n.rcnt = 4'h0;
               n.poll = 1'b0;
               n.ptmr = '0;
               if (cmd_op == OP_RECOVER) begin
                  n.st = ST_RECOV;
                  n.step = S_RECOV;
               end else begin
                  n.st = ST_START;
                  n.step = (cmd_op == OP_READ_CUR) ? S_DEVR : S_DEVW;
               end
            end
         end
         ST_START: begin
            if (r.tick) begin
               n.qtr = r.qtr + 2'h1;
               unique case (r.qtr)
                  2'h0: n.scl = 1'b1;
                  2'h1: n.sda_oe = 1'b1;
                  2'h2: n.scl = 1'b0;
                  2'h3: begin
                     if (r.step == S_RECOV) begin
                        n.st = ST_STOP;
                        n.sda_oe = 1'b1;
                     end else begin
                        n.st = ST_BIT;
                        n.rx = 1'b0;
                        n.bit_cnt = 4'h0;
                        n.shreg = dev_byte;
                        n.sda_oe = ~dev_byte[7];
                     end
                  end
               endcase
            end
         end
         ST_LOAD: begin
            // Clock held low until the user supplies the byte
            if (r.wr_ready && wr_valid) begin
               n.wr_ready = 1'b0;
               n.st = ST_BIT;
               n.qtr = 2'h0;
               n.bit_cnt = 4'h0;
               n.rx = 1'b0;
               n.shreg = wr_data;
               n.sda_oe = ~wr_data[7];
            end
         end
         ST_BIT: begin
            if (r.tick) begin
               n.qtr = r.qtr + 2'h1;
               unique case (r.qtr)
                  2'h0: n.scl = 1'b1;
                  2'h1: begin
                     if (r.bit_cnt == 4'h8) begin
                        n.ack = sda_s;
                     end else if (r.rx) begin
                        n.shreg = {r.shreg[6:0], sda_s};
                     end
                  end
                  2'h2: n.scl = 1'b0;
                  2'h3: begin
                     n.bit_cnt = r.bit_cnt + 4'h1;
                     if (r.bit_cnt == 4'h7) begin
                        if (r.rx) begin
                           n.rd_data = r.shreg;
                           n.rd_valid = 1'b1;
                           n.sda_oe = (r.cnt != LEN_ONE);
                        end else begin
                           n.sda_oe = 1'b0;
                        end
                     end else if (r.bit_cnt != 4'h8) begin
                        n.shreg = r.rx ? r.shreg : {r.shreg[6:0], 1'b0};
                        n.sda_oe = r.rx ? 1'b0 : ~r.shreg[6];
                     end else if (r.rx) begin
                        n.cnt = r.cnt - LEN_ONE;
                        n.bit_cnt = 4'h0;
                        if (r.cnt == LEN_ONE) begin
                           n.st = ST_STOP;
                           n.sda_oe = 1'b1;
                        end else begin
                           n.sda_oe = 1'b0;
                        end
                     end else if (nak && r.step != S_POLL) begin
                        n.err = 1'b1;
                        n.poll = 1'b0;
                        n.st = ST_STOP;
                        n.sda_oe = 1'b1;
                     end else begin
                        n.bit_cnt = 4'h0;
                        unique case (r.step)
                           S_DEVW: begin
                              n.step = S_AH;
                              n.shreg = r.addr[15:8];
                              n.sda_oe = ~r.addr[15];
                           end
                           S_AH: begin
                              n.step = S_AL;
                              n.shreg = r.addr[7:0];
                              n.sda_oe = ~r.addr[7];
                           end
                           S_AL: begin
                              if (r.op == OP_WRITE) begin
                                 n.step = S_DATA;
                                 n.st = ST_LOAD;
                                 n.wr_ready = 1'b1;
                              end else begin
                                 n.step = S_DEVR;
                                 n.st = ST_START;
                                 n.qtr = 2'h0;
                                 n.sda_oe = 1'b0;
                              end
                           end
                           S_DATA: begin
                              n.cnt = r.cnt - LEN_ONE;
                              if (r.cnt == LEN_ONE) begin
                                 n.st = ST_STOP;
                                 n.sda_oe = 1'b1;
                                 n.poll = 1'b1;
                                 n.ptmr = '0;
                              end else begin
                                 n.st = ST_LOAD;
                                 n.wr_ready = 1'b1;
                              end
                           end
                           S_DEVR: begin
                              n.step = S_RDATA;
                              n.rx = 1'b1;
                              n.sda_oe = 1'b0;
                           end
                           S_POLL: begin
                              n.st = ST_STOP;
                              n.sda_oe = 1'b1;
                              n.poll = nak && r.ptmr != PROG_LIM;
                              n.err = nak && r.ptmr == PROG_LIM;
                           end
                           default: begin
                              n.st = ST_STOP;
                              n.sda_oe = 1'b1;
                              n.err = 1'b1;
                           end
                        endcase
                     end
                  end
               endcase
            end
         end
         ST_STOP: begin
            if (r.tick) begin
               n.qtr = r.qtr + 2'h1;
               unique case (r.qtr)
                  2'h0: n.scl = 1'b1;
                  2'h1: n.sda_oe = 1'b0;
                  2'h2: n.scl = 1'b1;
                  2'h3: begin
                     if (r.poll) begin
                        n.st = ST_START;
                        n.step = S_POLL;
                     end else begin
                        n.st = ST_IDLE;
                        n.busy = 1'b0;
                        n.done = 1'b1;
                     end
                  end
               endcase
            end
         end
         ST_RECOV: begin
            n.sda_oe = 1'b0;
            if (r.tick) begin
               n.qtr = r.qtr + 2'h1;
               unique case (r.qtr)
                  2'h0: n.scl = 1'b0;
                  2'h1: n.scl = 1'b1;
                  2'h2: begin
                     if (sda_s) begin
                        n.st = ST_START;
                        n.qtr = 2'h0;
                     end else if (r.rcnt == REC_LAST) begin
                        n.st = ST_IDLE;
                        n.err = 1'b1;
                        n.busy = 1'b0;
                        n.done = 1'b1;
                     end else begin
                        n.rcnt = r.rcnt + 4'h1;
                     end
                  end
                  2'h3: n.scl = 1'b1;
               endcase
            end
         end
      endcase
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= REG_RST;
      end else begin
         r <= n;
      end
   end

   assign cmd_ready = r.cmd_ready;
   assign busy = r.busy;
   assign done = r.done;
   assign err = r.err;
   assign wr_ready = r.wr_ready;
   assign rd_valid = r.rd_valid;
   assign rd_data = r.rd_data;
   assign wp = r.wp;
   assign scl_o = r.scl;
   assign sda_o = r.sda_o;
   assign sda_oe = r.sda_oe;
endmodule : sep_host
`default_nettype wire

// file: design/sep_pkg.sv
// Constants, types and state layout of the serial EEPROM bus controller
package sep_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_KHZ = 50000;
   localparam int SCL_KHZ_DEF = 400;
   localparam int QTR_CYC_DEF = CLK_KHZ / (4 * SCL_KHZ_DEF);
   localparam int DIV_W = 8;
   localparam int PROG_TIME_MS = 5;
   localparam int PROG_CYC_DEF = PROG_TIME_MS * CLK_KHZ;
   localparam int PTMR_W = 20;
   localparam int REC_PULSES = 9;
   // ==========================================================
   // Memory shape
   localparam int PAGE_BYTES = 64;
   localparam int ADDR_W_SMALL = 14;
   localparam int ADDR_W_LARGE = 15;
   localparam int LEN_W = 16;
   localparam logic [LEN_W-1:0] LEN_ONE = 16'h0001;
   localparam logic [LEN_W-1:0] LEN_PAGE = 16'h0040;
   // Arbitrary neutral value; set to the real prefix at integration
   localparam logic [3:0] DEV_TYPE_DEF = 4'h5;
   // ==========================================================
   // Commands
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ_CUR = 2'h1;
   localparam logic [1:0] OP_READ_RAND = 2'h2;
   localparam logic [1:0] OP_RECOVER = 2'h3;
   // ==========================================================
   // States
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_START = 6'h02,
      ST_BIT = 6'h04,
      ST_LOAD = 6'h08,
      ST_STOP = 6'h10,
      ST_RECOV = 6'h20
   } sep_state_t;
   typedef enum logic [7:0] {
      S_DEVW = 8'h01,
      S_AH = 8'h02,
      S_AL = 8'h04,
      S_DATA = 8'h08,
      S_DEVR = 8'h10,
      S_RDATA = 8'h20,
      S_POLL = 8'h40,
      S_RECOV = 8'h80
   } sep_step_t;
   typedef struct packed {
      sep_state_t st;
      sep_step_t step;
      logic [1:0] op;
      logic [1:0] qtr;
      logic [DIV_W-1:0] div;
      logic tick;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic rx;
      logic ack;
      logic poll;
      logic [PTMR_W-1:0] ptmr;
      logic [3:0] rcnt;
      logic [LEN_W-1:0] cnt;
      logic [15:0] addr;
      logic [2:0] cs;
      logic scl;
      logic sda_o;
      logic sda_oe;
      logic wp;
      logic cmd_ready;
      logic wr_ready;
      logic rd_valid;
      logic [7:0] rd_data;
      logic busy;
      logic done;
      logic err;
   } sep_reg_t;
   localparam sep_reg_t REG_RST = '{st: ST_IDLE, step: S_DEVW, scl: 1'b1, default: '0};
endpackage : sep_pkg

// file: design/sep_sync.sv
// Two-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ps
`default_nettype none
module sep_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sep_sync_t;
   sep_sync_t r, n;
   // ==========================================================
   // Chain; first stage feeds only the second
   always_comb begin
      n.s1 = d;
      n.s2 = r.s1;
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         r <= '1;
      end else begin
         r <= n;
      end
   end
   assign q = r.s2;
endmodule : sep_sync
`default_nettype wire

// file: tb/sep_eeprom_model.sv
// Behavioural two-wire serial EEPROM on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_model #(
   // Arbitrary prefix; must equal the controller's
   parameter logic [3:0] DEV_TYPE = 4'h5,
   parameter logic [2:0] CS = 3'h0,
   parameter int AW = 15,
   parameter int BUSY_NS = 1000
) (
   // Bus pins
   input wire logic scl,
   input wire logic sda,
   input wire logic wp,
   // Holds data low to mimic a target stuck mid-byte
   input wire logic stuck,
   output logic pull_o
);
   localparam logic [14:0] MASK = 15'((16'h1 << AW) - 16'h1);
   logic [7:0] mem [0:32767];
   logic [7:0] sh, ah, rb;
   logic [14:0] addr;
   logic act, rd, wrote, pull;
   int bcnt, ph;
   time t_free;
   assign pull_o = pull | stuck;
   initial begin
      for (int i = 0; i < 32768; i++) mem[i] = i[7:0];
      {act, rd, wrote, pull, addr, bcnt, ph, t_free} = '0;
   end
   // ==========================================
   // Start and stop, seen while the clock is high
   always @(negedge sda) if (scl === 1'b1) begin
      {act, bcnt, ph, rd, pull} = {1'b1, 64'h0, 2'h0};
   end
   always @(posedge sda) if (scl === 1'b1) begin
      act = 1'b0;
      if (wrote) t_free = $time + BUSY_NS;
      wrote = 1'b0;
   end
   // ==========================================
   // Sample on the rising clock, drive on the falling clock
   always @(posedge scl) if (act) begin
      if (bcnt < 8) sh = {sh[6:0], sda};
      else if (rd && sda) act = 1'b0;
      bcnt++;
   end
   always @(negedge scl) if (act) begin
      if (bcnt == 8) begin
         if (ph == 0) begin
            rd = sh[0];
            act = (sh[7:1] == {DEV_TYPE, CS}) && ($time >= t_free);
            pull = act;
         end else if (rd) pull = 1'b0;
         else begin
            if (ph == 1) ah = sh;
            else if (ph == 2) addr = 15'({ah, sh}) & MASK;
            else begin
               if (!wp) mem[addr] = sh;
               addr[5:0] = addr[5:0] + 6'h1;
               wrote = 1'b1;
            end
            pull = 1'b1;
         end
         ph = ph + int'(ph < 3);
      end else if (bcnt == 9) begin
         bcnt = 0;
         pull = 1'b0;
         if (rd) begin
            rb = mem[addr];
            addr = (addr + 15'h1) & MASK;
         end
      end
      if (rd && bcnt < 8) pull = !rb[7 - bcnt];
   end
endmodule : sep_eeprom_model
`default_nettype wire

// file: tb/sep_host_chk.sv
// Port checks of the serial EEPROM bus controller
`timescale 1ns/1ps
`default_nettype none
module sep_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Handshakes
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire logic busy,
   input wire logic done,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic [7:0] wr_data,
   // Pins
   input wire logic write_protect,
   input wire logic wp,
   input wire logic scl_o,
   input wire logic sda_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // ==========================================
   // Pin relations
   property p_wp; !$past(srst, 2) |-> wp == $past(write_protect); endproperty
   a_wp: assert property (p_wp) else $error("wp pin lag wrong");
   property p_start; scl_o && $past(scl_o) && $rose(sda_oe) |-> busy; endproperty
   a_start: assert property (p_start) else $error("start outside command");
   property p_stop; scl_o && $past(scl_o) && $fell(sda_oe) |=> (scl_o && !sda_oe) [*3]; endproperty
   a_stop: assert property (p_stop) else $error("bus not free after stop");
   property p_msb; wr_valid && wr_ready |=> !wr_ready && (sda_oe == !$past(wr_data[7])); endproperty
   a_msb: assert property (p_msb) else $error("first data bit wrong");
   property p_idle; cmd_ready |-> scl_o && !sda_oe; endproperty
   a_idle: assert property (p_idle) else $error("bus held while idle");
   // Stalling keeps the clock low so data may change safely
   property p_stall; wr_ready |-> !scl_o; endproperty
   a_stall: assert property (p_stall) else $error("clock high while waiting");
   // ==========================================
   // Command handshake
   property p_take; cmd_valid && cmd_ready |=> !cmd_ready && busy; endproperty
   a_take: assert property (p_take) else $error("take not seen");
   property p_done; done |-> !busy && !cmd_ready ##1 !done && cmd_ready; endproperty
   a_done: assert property (p_done) else $error("done sequence wrong");
   property p_busy; $rose(busy) |-> $past(cmd_valid && cmd_ready); endproperty
   a_busy: assert property (p_busy) else $error("busy without take");
endmodule : sep_chk
bind sep_host sep_chk u_chk (.clk(clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
   .busy(busy), .done(done), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
   .write_protect(write_protect), .wp(wp), .scl_o(scl_o), .sda_oe(sda_oe));
`default_nettype wire

// file: tb/sep_host_tb.sv
// Self-checking bench of the serial EEPROM bus controller
`timescale 1ns/1ps
`default_nettype none
module sep_host_tb;
   import sep_pkg::*;
   // ==========================================
   // Setup
   localparam int QTR = 4;
   localparam int BUSY_NS = 30000;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic cmd_valid = 1'b0;
   logic wr_valid = 1'b0;
   logic write_protect = 1'b0;
   logic stuck = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [2:0] cmd_cs = 3'h0;
   logic [15:0] cmd_addr = 16'h0;
   logic [LEN_W-1:0] cmd_len = '0;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_data;
   logic cmd_ready, busy, done, err, wr_ready, rd_valid, wp, scl_o, sda_o, sda_oe, pull, last_err;
   wire logic sda_w;
   logic [7:0] q[$];
   logic [7:0] rxq[$];
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   // Pull-up on data: any party pulling low wins
   assign sda_w = !(sda_oe | pull);
   always #10 clk = ~clk;
   sep_host #(.QTR_CYC(QTR), .PROG_CYC(2000)) u_dut (.clk(clk), .srst(srst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_cs(cmd_cs), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
      .busy(busy), .done(done), .err(err), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .rd_valid(rd_valid), .rd_data(rd_data), .write_protect(write_protect), .wp(wp), .scl_o(scl_o),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
   sep_eeprom_model #(.DEV_TYPE(DEV_TYPE_DEF), .CS(3'h2), .BUSY_NS(BUSY_NS)) u_mem (.scl(scl_o),
      .sda(sda_w), .wp(wp), .stuck(stuck), .pull_o(pull));
   // Taken mid-cycle, where the one-cycle pulse has settled
   always @(negedge clk) if (rd_valid === 1'b1) rxq.push_back(rd_data);
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_fail++;
         finish_test;
      end
   end
   // ==========================================
   // Shared tasks
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   // Offers one command, feeds q on demand, returns at done
   task automatic run(input logic [1:0] op, input logic [2:0] cs, input logic [15:0] a, input int n);
      int k;
      int i;
      i = 0;
      for (k = 0; k < 2000 && cmd_ready !== 1'b1; k++) @(negedge clk);
      cmd_op = op;
      cmd_cs = cs;
      cmd_addr = a;
      cmd_len = LEN_W'(n);
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
      for (k = 0; k < 30000 && done !== 1'b1; k++) begin
         if (wr_valid === 1'b1) wr_valid = 1'b0;
         else if (wr_ready === 1'b1 && i < q.size()) begin
            wr_data = q[i];
            wr_valid = 1'b1;
            i++;
         end
         @(negedge clk);
      end
      check("done", done, 1'b1);
      wr_valid = 1'b0;
      last_err = err;
   endtask : run
   task automatic expect_rx(input string what, input logic [7:0] e[$]);
      check({what, " n"}, 16'(rxq.size()), 16'(e.size()));
      foreach (e[j]) if (j < rxq.size()) check(what, rxq[j], e[j]);
      rxq = {};
   endtask : expect_rx
   // ==========================================
   // Scenarios
   task automatic t_reset;
      check("scl idle", scl_o, 1'b1);
      check("sda idle", sda_oe, 1'b0);
      check("sda level", sda_o, 1'b0);
      @(negedge clk);
      check("ready", cmd_ready, 1'b1);
   endtask : t_reset
   // Page write crossing the page end, then reads around it
   task automatic t_page;
      time t0;
      q = {8'h11, 8'h22, 8'h33, 8'h44};
      t0 = $time;
      run(OP_WRITE, 3'h2, 16'h013e, 4);
      check("wr err", last_err, 1'b0);
      check("prog wait", 16'(($time - t0) > BUSY_NS + 65 * 4 * QTR * 20), 16'h1);
      run(OP_READ_RAND, 3'h2, 16'h013e, 4);
      expect_rx("wrap rd", {8'h11, 8'h22, 8'h40, 8'h41});
      run(OP_READ_RAND, 3'h2, 16'h0100, 2);
      expect_rx("page start", {8'h33, 8'h44});
      run(OP_READ_CUR, 3'h2, 16'h0000, 1);
      expect_rx("cur rd", {8'h02});
   endtask : t_page
   task automatic t_top;
      run(OP_READ_RAND, 3'h2, 16'h7fff, 2);
      expect_rx("top wrap", {8'hff, 8'h00});
   endtask : t_top
   // Wrong select, then a protected write: neither may land
   task automatic t_protect;
      q = {8'h99};
      run(OP_WRITE, 3'h5, 16'h0200, 1);
      check("cs miss", last_err, 1'b1);
      write_protect = 1'b1;
      q = {8'hc3};
      run(OP_WRITE, 3'h2, 16'h0200, 1);
      check("wp pin", wp, 1'b1);
      write_protect = 1'b0;
      run(OP_READ_RAND, 3'h2, 16'h0200, 1);
      expect_rx("kept", {8'h00});
   endtask : t_protect
   task automatic t_recover;
      run(OP_RECOVER, 3'h0, 16'h0, 1);
      check("recov ok", last_err, 1'b0);
      stuck = 1'b1;
      run(OP_RECOVER, 3'h0, 16'h0, 1);
      check("recov stuck", last_err, 1'b1);
      stuck = 1'b0;
   endtask : t_recover
   initial begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      t_reset;
      t_page;
      t_top;
      t_protect;
      t_recover;
      finish_test;
   end
endmodule : sep_host_tb
`default_nettype wire
